// ==== core/indirect_access_regs.svh ====
/*
 * Register offsets, field positions and reset values of the
 * indirect register access port. Assumes inclusion by bare name from core/.
 */
// Functional notes
// - Select code 0000 in control bits 5:2 routes accesses to the pattern and timing block.
// - With auto-increment set, the offset steps by 1 after each completed indirect access.
// - With read-enable set, an offset register write issues a read strobe at the new offset.
// - With read-enable and auto-increment set, each data read issues a further read strobe.
// - The offset register is 8 bits and resets to 0x3a.
// - A data write stores the byte and writes it to the selected block at the current offset.
// - A data register read returns the selected block register at the current offset.
// - Control resets with select 0x7, auto-increment and read-enable clear; bits 7:6 read 0.
// - The data register nominally resets to 0x14, but tests must tolerate other values.
`ifndef INDIRECT_ACCESS_REGS_SVH
`define INDIRECT_ACCESS_REGS_SVH

// ****************************************************************
// Byte addresses (index times four)
// ****************************************************************
`define IDX_CONTROL 8'hb0
`define IDX_OFFSET 8'hb1
`define IDX_DATA 8'hb2
`define ADDR_CONTROL 10'h2c0
`define ADDR_OFFSET 10'h2c4
`define ADDR_DATA 10'h2c8

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define SEL_HI 5
`define SEL_LO 2
`define AUTO_INC_BIT 1
`define READ_EN_BIT 0
`define SEL_TEST_PATTERN 4'h0
`define CONTROL_RESET 8'h1c
`define OFFSET_RESET 8'h3a
`define DATA_RESET 8'h14

// ****************************************************************
// AXI responses
// ****************************************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== core/indirect_access_pkg.sv ====
/*
 * Types of the indirect register access port.
 * Assumes nothing of its surroundings.
 */
package indirect_access_pkg;
  typedef enum logic [1:0] {
    REG_CONTROL,
    REG_OFFSET,
    REG_DATA,
    REG_NONE
  } reg_sel_t;
endpackage

// ==== core/indirect_register_access_port.sv ====
/*
 * Indirect register access port: AXI4-Lite slave holding the control,
 * offset and data window registers, driving strobed byte accesses into
 * the selected internal block.
 * Assumes the block answers reads combinationally in the cycle of blk_rd_strobe
 * or any cycle, via blk_rdata reflecting the addressed register.
 */
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "indirect_access_regs.svh"

module indirect_register_access_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] target_block_select,
  output logic [7:0] target_offset,
  output logic [7:0] blk_wdata,
  output logic blk_wr_strobe,
  output logic blk_rd_strobe,
  output logic test_pattern_and_lane_timing_block_sel,
  input wire logic [7:0] blk_rdata
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic indirect_access_pkg::reg_sel_t decode(input logic [9:0] addr);
    if (addr == `ADDR_CONTROL) begin
      return indirect_access_pkg::REG_CONTROL;
    end else if (addr == `ADDR_OFFSET) begin
      return indirect_access_pkg::REG_OFFSET;
    end else if (addr == `ADDR_DATA) begin
      return indirect_access_pkg::REG_DATA;
    end
    return indirect_access_pkg::REG_NONE;
  endfunction

  // ****************************************************************
  // Storage and handshake state
  // ****************************************************************
  logic [3:0] sel_field;
  logic offset_auto_increment;
  logic read_strobe_enable;
  logic [7:0] indirect_offset;
  logic [7:0] window_byte;
  logic aw_held;
  logic w_held;
  logic [9:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic do_write;
  logic do_read;
  indirect_access_pkg::reg_sel_t wsel;
  indirect_access_pkg::reg_sel_t rsel;
  logic [7:0] read_byte;
  logic [7:0] control_value;
  logic data_wr;
  logic data_rd;
  logic offset_wr;
  logic control_wr;
  logic [1:0] next_bresp;
  logic [1:0] next_rresp;
  logic [7:0] next_offset;
  logic [7:0] next_target_offset;
  logic next_rd_strobe;

  // ****************************************************************
  // Register write qualification
  // ****************************************************************
  // A write lands only with byte lane 0 enabled; the other lanes hold no bits
  function automatic logic write_hit(input indirect_access_pkg::reg_sel_t which);
    return do_write && w_lane0 && (wsel == which);
  endfunction

  // ****************************************************************
  // Write channel capture
  // ****************************************************************
  // Both channels stall while a response waits, so only one write is in flight
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wsel = decode(aw_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end
  end

  // ****************************************************************
  // Write response
  // ****************************************************************
  // Unmapped addresses answer with an error and change nothing
  always_comb begin
    if (wsel == indirect_access_pkg::REG_NONE) begin
      next_bresp = `RESP_SLVERR;
    end else begin
      next_bresp = `RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bresp <= next_bresp;
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign rsel = decode(s_axi_araddr);
  assign control_value = {2'b00, sel_field, offset_auto_increment, read_strobe_enable};

  // The window is no stored copy: it always shows the block at the offset
  always_comb begin
    unique case (rsel)
      indirect_access_pkg::REG_CONTROL: read_byte = control_value;
      indirect_access_pkg::REG_OFFSET: read_byte = indirect_offset;
      indirect_access_pkg::REG_DATA: read_byte = blk_rdata;
      indirect_access_pkg::REG_NONE: read_byte = 8'h00;
    endcase
  end

  always_comb begin
    if (rsel == indirect_access_pkg::REG_NONE) begin
      next_rresp = `RESP_SLVERR;
    end else begin
      next_rresp = `RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Upper bytes read as zero: every register is one byte wide
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h00000000;
    end else if (do_read) begin
      s_axi_rdata <= {24'h000000, read_byte};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rresp <= `RESP_OKAY;
    end else if (do_read) begin
      s_axi_rresp <= next_rresp;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  assign control_wr = write_hit(indirect_access_pkg::REG_CONTROL);

  // Reserved select codes are kept as written; only 0000 raises the block flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_field <= 4'(`CONTROL_RESET >> `SEL_LO);
    end else if (control_wr) begin
      sel_field <= w_byte[`SEL_HI:`SEL_LO];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offset_auto_increment <= 1'b0;
    end else if (control_wr) begin
      offset_auto_increment <= w_byte[`AUTO_INC_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_strobe_enable <= 1'b0;
    end else if (control_wr) begin
      read_strobe_enable <= w_byte[`READ_EN_BIT];
    end
  end

  // ****************************************************************
  // Offset and data window
  // ****************************************************************
  assign data_wr = write_hit(indirect_access_pkg::REG_DATA);
  assign offset_wr = write_hit(indirect_access_pkg::REG_OFFSET);
  assign data_rd = do_read && (rsel == indirect_access_pkg::REG_DATA);

  // A host write of the offset wins over an increment in the same cycle
  always_comb begin
    if (offset_wr) begin
      next_offset = w_byte;
    end else if (offset_auto_increment && (data_wr || data_rd)) begin
      next_offset = indirect_offset + 8'h01;
    end else begin
      next_offset = indirect_offset;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      indirect_offset <= `OFFSET_RESET;
    end else begin
      indirect_offset <= next_offset;
    end
  end

  // The stored byte is what the block is given, so both always agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      window_byte <= `DATA_RESET;
    end else if (data_wr) begin
      window_byte <= w_byte;
    end
  end

  assign blk_wdata = window_byte;

  // ****************************************************************
  // Strobes to the selected block
  // ****************************************************************
  // A write strobe keeps the offset it was issued at; otherwise follow the offset
  always_comb begin
    if (data_wr) begin
      next_target_offset = indirect_offset;
    end else begin
      next_target_offset = next_offset;
    end
  end

  always_comb begin
    next_rd_strobe = 1'b0;
    if (read_strobe_enable && offset_wr) begin
      next_rd_strobe = 1'b1;
    end
    if (read_strobe_enable && offset_auto_increment && data_rd) begin
      next_rd_strobe = 1'b1;
    end
  end

  // Strobes are registered so they accompany the offset they target
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_wr_strobe <= 1'b0;
    end else begin
      blk_wr_strobe <= data_wr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      target_offset <= 8'h00;
    end else begin
      target_offset <= next_target_offset;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_rd_strobe <= 1'b0;
    end else begin
      blk_rd_strobe <= next_rd_strobe;
    end
  end

  // ****************************************************************
  // Block selection
  // ****************************************************************
  assign target_block_select = sel_field;
  assign test_pattern_and_lane_timing_block_sel = (sel_field == `SEL_TEST_PATTERN);

endmodule

// ==== tb/indirect_access_properties.sv ====
/* Concurrent checks on the indirect access port.
   Assumes it is bound to the port's top module. */
`timescale 1ns/10ps
module indirect_access_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] target_block_select,
  input wire logic [7:0] target_offset,
  input wire logic blk_wr_strobe,
  input wire logic blk_rd_strobe,
  input wire logic test_pattern_and_lane_timing_block_sel
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_sel_flag: assert property (test_pattern_and_lane_timing_block_sel ==
    (target_block_select == 4'h0)) else $error("select flag wrong");
  chk_wr_pulse: assert property (blk_wr_strobe |=> !blk_wr_strobe)
    else $error("write strobe too long");
  chk_wr_resp: assert property (blk_wr_strobe |-> $rose(s_axi_bvalid))
    else $error("write strobe without response");
  chk_rd_pulse: assert property (blk_rd_strobe |=> !blk_rd_strobe)
    else $error("read strobe too long");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  // Offset writes land with the response, so only other changes must be steps of one
  chk_offset_step: assert property ($past(aresetn) && $past(aresetn, 2) &&
    $changed(target_offset) && !s_axi_bvalid && !$past(s_axi_bvalid)
    |-> target_offset == $past(target_offset) + 8'h01) else $error("offset jumped");
endmodule
bind indirect_register_access_port indirect_access_properties chk (.aclk, .aresetn,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
  .s_axi_bready, .target_block_select, .target_offset, .blk_wr_strobe, .blk_rd_strobe,
  .test_pattern_and_lane_timing_block_sel);

// ==== tb/tb_indirect_register_access_port.sv ====
/* Register-level bench of the indirect access port.
   Assumes a byte-wide block model answering at the held offset. */
`timescale 1ns/10ps
`include "indirect_access_regs.svh"
module tb_indirect_register_access_port;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] awaddr = 10'h0, araddr = 10'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, wr_stb, rd_stb, sel0;
  logic [1:0] bresp, rresp;
  logic [3:0] sel;
  logic [7:0] offs, bwd;
  logic [7:0] mem [256];
  int fail_count = 0, n_compared = 0, rd_cnt = 0;
  logic [7:0] rd_off;
  indirect_register_access_port DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .target_block_select(sel), .target_offset(offs), .blk_wdata(bwd),
    .blk_wr_strobe(wr_stb), .blk_rd_strobe(rd_stb),
    .test_pattern_and_lane_timing_block_sel(sel0), .blk_rdata(mem[offs]));
  initial begin
    forever #50 aclk = ~aclk;
  end
  // Block model: distinct contents per offset so a wrong offset shows
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
  end
  always @(posedge aclk) begin
    if (wr_stb === 1'b1) mem[offs] <= bwd;
    if (rd_stb === 1'b1) begin
      rd_cnt++;
      rd_off = offs;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Handshakes are decided at rising edges; an idle edge separates two calls
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
    bit ah = 0, wh = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!ah && awready === 1'b1) begin
        ah = 1;
        awvalid <= 1'b0;
      end
      if (!wh && wready === 1'b1) begin
        wh = 1;
        wvalid <= 1'b0;
      end
    end while (!(ah && wh));
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk(rdata, {24'h0, ed});
    chk({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge aclk);
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`ADDR_CONTROL, 8'h1c, `RESP_OKAY);
    rd(`ADDR_OFFSET, 8'h3a, `RESP_OKAY);
    chk({28'h0, sel}, 32'h7);
    rd(10'h3fc, 8'h00, `RESP_SLVERR);
    wr(10'h3fc, 8'h77, `RESP_SLVERR);
    $display("test reset and decode done");
    wr(`ADDR_CONTROL, 8'h00, `RESP_OKAY);
    chk({31'h0, sel0}, 32'h1);
    wr(`ADDR_OFFSET, 8'h10, `RESP_OKAY);
    wr(`ADDR_DATA, 8'ha5, `RESP_OKAY);
    rd(`ADDR_DATA, 8'ha5, `RESP_OKAY);
    rd(`ADDR_OFFSET, 8'h10, `RESP_OKAY);
    $display("test plain window done");
    wr(`ADDR_CONTROL, 8'h02, `RESP_OKAY);
    wr(`ADDR_OFFSET, 8'hff, `RESP_OKAY);
    wr(`ADDR_DATA, 8'h11, `RESP_OKAY);
    rd(`ADDR_OFFSET, 8'h00, `RESP_OKAY);
    rd(`ADDR_DATA, 8'h5a, `RESP_OKAY);
    rd(`ADDR_OFFSET, 8'h01, `RESP_OKAY);
    chk({24'h0, mem[8'hff]}, 32'h11);
    $display("test auto increment done");
    wr(`ADDR_CONTROL, 8'hc1, `RESP_OKAY);
    rd(`ADDR_CONTROL, 8'h01, `RESP_OKAY);
    rd_cnt = 0;
    wr(`ADDR_OFFSET, 8'h20, `RESP_OKAY);
    chk(rd_cnt, 1);
    chk({24'h0, rd_off}, 32'h20);
    rd(`ADDR_DATA, 8'h7a, `RESP_OKAY);
    chk(rd_cnt, 1);
    wr(`ADDR_CONTROL, 8'h03, `RESP_OKAY);
    rd(`ADDR_DATA, 8'h7a, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(rd_cnt, 2);
    chk({24'h0, rd_off}, 32'h21);
    $display("test read strobes done");
    complete_run();
  end
endmodule
